// >>> verilog/mib_counter_indirect_read.sv
// Statistics counter store of a five-port switch, indirect read window.
// Assumes the serial register access logic presents one-cycle read and
// write strobes on ref_clk, and that traffic events are ref_clk pulses.
//
// Overview of operation
// [R01] 32 counters per port, indirect access only
// [R02] Byte entry: count 35:0, overflow 38, valid 37
// [R03] Drop entry: count 15:0, zeros 36:16
// [R04] Every counter clears when the host reads it
// [R05] Ports 4, 5 aggregated at 0x10C and 0x110
// [R06] Receive bytes count all packets, errored too
// [R07] Transmit bytes count good packets, pause included
// [R08] Drop counters count packets lost for resources
// [R09] Host writes 0x1c to select per-port table
// [R10] Writing index register triggers the counter fetch
// [R11] Host selects 0x1d for aggregated table reads
// [R12] Data bytes return bits 39:32 down to 7:0
// [R13] Bit 38 flags wrap since last clear
// [R14] Host reads all counters within 30 seconds
// [R15] Port bases 0x20 apart, same offset layout
// [R16] Ports 1 to 3 aggregated at 0x100..0x10B
// [R17] Host retries fetch while valid bit clear; bench get retries once only
`timescale 1ns/1ps
`include "mib_cfg.svh"

module mib_counter_indirect_read #(
  parameter int NPORT = 5,
  parameter int NCNT  = 32,
  parameter int LEN_W = 11
) (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  // Host register port
  input  wire logic [7:0]                reg_addr,
  input  wire logic                      reg_wr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata,
  output logic                           fetch_busy,
  // Per-port counter events, counter c of port p at bit p*NCNT+c
  input  wire logic [NPORT*NCNT-1:0]     port_evt,
  // Packet completion from the MACs
  input  wire logic [NPORT-1:0]          rx_done,
  input  wire logic [NPORT-1:0][LEN_W-1:0] rx_len,
  input  wire logic [NPORT-1:0]          tx_done,
  input  wire logic [NPORT-1:0]          tx_ok,
  input  wire logic [NPORT-1:0][LEN_W-1:0] tx_len,
  // Resource drops from the queue manager
  input  wire logic [NPORT-1:0]          rx_drop,
  input  wire logic [NPORT-1:0]          tx_drop
);
  import mib_pkg::*;

  localparam logic [35:0] BYTE_MASK = {36{1'b1}};
  localparam logic [35:0] DROP_MASK =
    {{(36 - `MIB_DROP_WIDTH){1'b0}}, {`MIB_DROP_WIDTH{1'b1}}};

  typedef struct packed {
    fetch_state_t                st;
    logic [7:0]                  sel;
    logic [7:0]                  idx;
    logic [39:0]                 data;
    logic [7:0]                  rdata;
    logic [NPORT-1:0][35:0]      rxb;
    logic [NPORT-1:0][35:0]      txb;
    logic [NPORT-1:0][15:0]      rxd;
    logic [NPORT-1:0][15:0]      txd;
    logic [NPORT-1:0][3:0]       ovf;
  } top_st_t;

  top_st_t s_r;
  top_st_t s_nxt;

  logic [8:0]              fidx;
  logic                    trig;
  logic                    pp_hit;
  logic                    agg_hit;
  logic [8:0]              agg_off;
  logic [2:0]              agg_port;
  logic [1:0]              agg_kind;
  logic [`MIB_PP_WIDTH-1:0] pp_val;
  logic                    pp_ovf;
  logic                    pp_ack;
  logic [36:0]             r_rxb;
  logic [36:0]             r_txb;
  logic [36:0]             r_rxd;
  logic [36:0]             r_txd;
  logic [3:0]              clr;
  logic [35:0]             agg_val;
  logic                    agg_ovf;

  // Entry layout shared by all tables; unused high bits stay zero
  function automatic logic [39:0] entry(input logic ovf,
                                        input logic valid,
                                        input logic [35:0] val);
    logic [39:0] e;
    e = `MIB_ENTRY_RST;
    e[`MIB_BIT_OVF] = ovf; // [R13]
    e[`MIB_BIT_VALID] = valid;
    e[35:0] = val; // [R02] [R03]
    return e;
  endfunction

  // Index decode: per-port table below 0xA0, aggregated 0x100..0x113
  always_comb begin
    fidx = (s_r.sel == `MIB_SEL_AGG_TABLE) ? {1'b1, reg_wdata}
                                           : {1'b0, reg_wdata};
    trig = reg_wr && (reg_addr == `MIB_OFF_INDEX) &&
           (s_r.st == F_IDLE) &&
           ((s_r.sel == `MIB_SEL_PORT_TABLE) ||
            (s_r.sel == `MIB_SEL_AGG_TABLE)); // [R10]
    pp_hit = trig && (fidx < `MIB_PORT_END); // [R15]
    agg_hit = trig && (fidx >= `MIB_AGG_BASE) &&
              (fidx < `MIB_AGG_END); // [R05] [R16]
    agg_off = fidx - `MIB_AGG_BASE;
    agg_port = agg_off[4:2];
    agg_kind = agg_off[1:0];
  end

  mib_port_counters #(
    .NPORT (NPORT),
    .NCNT  (NCNT),
    .CW    (`MIB_PP_WIDTH)
  ) u_port_counters (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .evt     (port_evt),
    .rd_en   (pp_hit),
    .rd_sel  (fidx[7:0]),
    .rd_val  (pp_val),
    .rd_ovf  (pp_ovf),
    .rd_ack  (pp_ack)
  ); // [R01]

  always_comb begin
    s_nxt = s_r;
    r_rxb = '0;
    r_txb = '0;
    r_rxd = '0;
    r_txd = '0;
    clr = '0;
    agg_val = '0;
    agg_ovf = 1'b0;

    // Register writes; data bytes are read-only
    if (reg_wr && (reg_addr == `MIB_OFF_TABLE_SEL)) begin
      s_nxt.sel = reg_wdata;
    end
    if (reg_wr && (reg_addr == `MIB_OFF_INDEX)) begin
      s_nxt.idx = reg_wdata;
    end

    // Register reads, answered one cycle later
    if (reg_rd) begin
      if (reg_addr == `MIB_OFF_TABLE_SEL) begin
        s_nxt.rdata = s_r.sel;
      end else if (reg_addr == `MIB_OFF_INDEX) begin
        s_nxt.rdata = s_r.idx;
      end else if (reg_addr == `MIB_OFF_DATA4) begin
        s_nxt.rdata = s_r.data[39:32]; // [R12]
      end else if (reg_addr == `MIB_OFF_DATA3) begin
        s_nxt.rdata = s_r.data[31:24];
      end else if (reg_addr == `MIB_OFF_DATA2) begin
        s_nxt.rdata = s_r.data[23:16];
      end else if (reg_addr == `MIB_OFF_DATA1) begin
        s_nxt.rdata = s_r.data[15:8];
      end else if (reg_addr == `MIB_OFF_DATA0) begin
        s_nxt.rdata = s_r.data[7:0];
      end else begin
        s_nxt.rdata = `MIB_REG_RST;
      end
    end

    // Aggregated fetch value, taken before this cycle's update
    if (agg_hit) begin
      case (agg_kind)
        `MIB_AGG_RXB: agg_val = s_r.rxb[agg_port];
        `MIB_AGG_TXB: agg_val = s_r.txb[agg_port];
        `MIB_AGG_RXD: agg_val = 36'(s_r.rxd[agg_port]);
        default:      agg_val = 36'(s_r.txd[agg_port]);
      endcase
      agg_ovf = s_r.ovf[agg_port][agg_kind];
    end

    // Fetch sequencing; valid stays low until the value is in place
    case (s_r.st)
      F_IDLE: begin
        if (pp_hit) begin
          s_nxt.data = `MIB_ENTRY_RST;
          s_nxt.st = F_WAIT;
        end else if (agg_hit) begin
          s_nxt.data = entry(agg_ovf, 1'b1, agg_val);
        end else if (trig) begin
          s_nxt.data = `MIB_ENTRY_RST;
        end
      end
      F_WAIT: begin
        if (pp_ack) begin
          s_nxt.data = entry(pp_ovf, 1'b1, 36'(pp_val));
          s_nxt.st = F_IDLE;
        end
      end
      default: begin
        s_nxt.st = F_IDLE;
      end
    endcase

    // Aggregated counters; a clear in the event cycle keeps the event
    for (int p = 0; p < NPORT; p++) begin
      for (int k = 0; k < 4; k++) begin
        clr[k] = agg_hit && (agg_port == 3'(p)) &&
                 (agg_kind == 2'(k)); // [R04]
      end
      r_rxb = add_cnt(clr[0] ? 36'h0_0000_0000 : s_r.rxb[p],
                      rx_done[p] ? 36'(rx_len[p]) : 36'h0_0000_0000,
                      BYTE_MASK); // [R06]
      r_txb = add_cnt(clr[1] ? 36'h0_0000_0000 : s_r.txb[p],
                      (tx_done[p] && tx_ok[p]) ? 36'(tx_len[p])
                                               : 36'h0_0000_0000,
                      BYTE_MASK); // [R07]
      r_rxd = add_cnt(clr[2] ? 36'h0_0000_0000 : 36'(s_r.rxd[p]),
                      {35'h0_0000_0000, rx_drop[p]}, DROP_MASK); // [R08]
      r_txd = add_cnt(clr[3] ? 36'h0_0000_0000 : 36'(s_r.txd[p]),
                      {35'h0_0000_0000, tx_drop[p]}, DROP_MASK); // [R08]
      s_nxt.rxb[p] = r_rxb[35:0];
      s_nxt.txb[p] = r_txb[35:0];
      s_nxt.rxd[p] = r_rxd[15:0];
      s_nxt.txd[p] = r_txd[15:0];
      s_nxt.ovf[p][0] = (s_r.ovf[p][0] && !clr[0]) || r_rxb[36]; // [R13]
      s_nxt.ovf[p][1] = (s_r.ovf[p][1] && !clr[1]) || r_txb[36]; // [R13]
      s_nxt.ovf[p][2] = (s_r.ovf[p][2] && !clr[2]) || r_rxd[36]; // [R13]
      s_nxt.ovf[p][3] = (s_r.ovf[p][3] && !clr[3]) || r_txd[36]; // [R13]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign fetch_busy = (s_r.st == F_WAIT);

endmodule // mib_counter_indirect_read

// >>> verilog/mib_cfg.svh
// Constants of the statistics counter store: offsets, selects, fields.
// Included by the package and the design files; definitions only.
`ifndef MIB_CFG_SVH
`define MIB_CFG_SVH

// Register offsets on the host register port
`define MIB_OFF_TABLE_SEL  8'h6e
`define MIB_OFF_INDEX      8'h6f
`define MIB_OFF_DATA4      8'h74
`define MIB_OFF_DATA3      8'h75
`define MIB_OFF_DATA2      8'h76
`define MIB_OFF_DATA1      8'h77
`define MIB_OFF_DATA0      8'h78
`define MIB_REG_RST        8'h00

// Table select codes
`define MIB_SEL_PORT_TABLE 8'h1c
`define MIB_SEL_AGG_TABLE  8'h1d

// Indirect index map
`define MIB_PORT_STRIDE    9'h020
`define MIB_PORT_END       9'h0a0
`define MIB_AGG_BASE       9'h100
`define MIB_AGG_END        9'h114
`define MIB_RX64_OFF       5'h0d
`define MIB_AGG_RXB        2'h0
`define MIB_AGG_TXB        2'h1
`define MIB_AGG_RXD        2'h2
`define MIB_AGG_TXD        2'h3

// Entry layout
`define MIB_BIT_OVF        38
`define MIB_BIT_VALID      37
`define MIB_PP_WIDTH       30
`define MIB_BYTE_WIDTH     36
`define MIB_DROP_WIDTH     16
`define MIB_ENTRY_RST      40'h00_0000_0000

`endif

// >>> verilog/mib_pkg.sv
// Types and shared arithmetic of the statistics counter store.
// Assumes mib_cfg.svh is on the include path.
`include "mib_cfg.svh"

package mib_pkg;

  typedef enum logic [1:0] {
    F_IDLE = 2'b00,
    F_WAIT = 2'b01
  } fetch_state_t;

  // Returns {wrapped, new value}; the mask gives the counter width
  function automatic logic [36:0] add_cnt(input logic [35:0] v,
                                          input logic [35:0] a,
                                          input logic [35:0] m);
    logic [36:0] sum;
    sum = {1'b0, v} + {1'b0, a};
    return {(sum > {1'b0, m}), (sum[35:0] & m)};
  endfunction

endpackage

// >>> verilog/mib_port_counters.sv
// Per-port event counter array with read-clear fetch port.
// Assumes event pulses come from logic on ref_clk.
`timescale 1ns/1ps
`include "mib_cfg.svh"

module mib_port_counters #(
  parameter int NPORT = 5,
  parameter int NCNT  = 32,
  parameter int CW    = `MIB_PP_WIDTH
) (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  // Count events, one bit per counter
  input  wire logic [NPORT*NCNT-1:0]    evt,
  // Fetch port
  input  wire logic                     rd_en,
  input  wire logic [7:0]               rd_sel,
  output logic      [CW-1:0]            rd_val,
  output logic                          rd_ovf,
  output logic                          rd_ack
);
  import mib_pkg::*;

  localparam int N = NPORT * NCNT;
  localparam logic [35:0] MASK = {{(36 - CW){1'b0}}, {CW{1'b1}}};

  typedef struct packed {
    logic [N-1:0][CW-1:0] cnt;
    logic [N-1:0]         ovf;
    logic [CW-1:0]        val;
    logic                 ovfo;
    logic                 ack;
  } pc_st_t;

  pc_st_t s_r;
  pc_st_t s_nxt;
  logic [36:0] res;
  logic        hit;

  always_comb begin
    s_nxt = s_r;
    res = '0;
    hit = 1'b0;
    s_nxt.ack = rd_en;
    if (rd_en) begin
      s_nxt.val = s_r.cnt[rd_sel];
      s_nxt.ovfo = s_r.ovf[rd_sel];
    end
    for (int i = 0; i < N; i++) begin
      // Read clears first, so an event in the fetch cycle is kept
      hit = rd_en && (rd_sel == 8'(i));
      res = add_cnt(hit ? 36'h0_0000_0000 : 36'(s_r.cnt[i]),
                    {35'h0_0000_0000, evt[i]}, MASK);
      s_nxt.cnt[i] = res[CW-1:0]; // [R04]
      s_nxt.ovf[i] = (s_r.ovf[i] && !hit) || res[36]; // [R13]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_val = s_r.val;
  assign rd_ovf = s_r.ovfo;
  assign rd_ack = s_r.ack;

endmodule // mib_port_counters

// >>> tb/mib_counter_indirect_read_props.sv
// Checker of the indirect counter read window.
// Sees only the host port of the top; bound at the foot.
`timescale 1ns/1ps
module mib_counter_indirect_read_props (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // Host register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       fetch_busy
);
  logic [7:0] sel_r, fsel_r, fidx_r;
  logic       t1_r, t2_r, trig, quiet, drop, pp;
  assign trig = reg_wr && reg_addr == 8'h6f && !fetch_busy &&
                (sel_r == 8'h1c || sel_r == 8'h1d);
  // Data may still be moving for two cycles after a trigger
  assign quiet = !trig && !t1_r && !t2_r;
  assign drop = fsel_r == 8'h1d && fidx_r[1] && fidx_r < 8'h14;
  assign pp = fsel_r == 8'h1c;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sel_r <= 8'h00;
      fsel_r <= 8'h00;
      fidx_r <= 8'h00;
      t1_r <= 1'b0;
      t2_r <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 8'h6e)
        sel_r <= reg_wdata;
      if (trig) begin
        fsel_r <= sel_r;
        fidx_r <= reg_wdata;
      end
      t1_r <= trig;
      t2_r <= t1_r;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_trig_busy: assert property (
    trig && sel_r == 8'h1c && reg_wdata < 8'ha0 |=> fetch_busy)
    else $error("no fetch");
  chk_busy_pulse: assert property (
    fetch_busy |=> !fetch_busy) else $error("busy too long");
  chk_busy_cause: assert property (
    $rose(fetch_busy) |-> $past(reg_wr) && $past(reg_addr) == 8'h6f)
    else $error("busy without trigger");
  chk_unmapped_zero: assert property (
    reg_rd && !(reg_addr inside {8'h6e, 8'h6f, [8'h74:8'h78]})
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  chk_sel_readback: assert property (
    reg_rd && reg_addr == 8'h6e |=> reg_rdata == $past(sel_r))
    else $error("select readback wrong");
  chk_top_reserved: assert property (
    reg_rd && reg_addr == 8'h74 && quiet |=> !reg_rdata[7] && !reg_rdata[4])
    else $error("reserved top bits set");
  chk_pp_reserved: assert property (
    reg_rd && quiet && pp && reg_addr == 8'h75 |=> reg_rdata[7:6] == 2'b00)
    else $error("per-port reserved bits set");
  chk_drop_reserved: assert property (
    reg_rd && quiet && drop && reg_addr inside {8'h75, 8'h76}
    |=> reg_rdata == 8'h00) else $error("drop reserved bits set");
endmodule // mib_counter_indirect_read_props

bind mib_counter_indirect_read mib_counter_indirect_read_props i_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .fetch_busy(fetch_busy));

// >>> tb/mib_host_model.sv
// Host model: byte writes and reads on the register port.
// Assumes the design takes strobes at the rising edge of ref_clk.
`timescale 1ns/1ps
module mib_host_model (
  // Clock
  input  wire logic       ref_clk,
  // Register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // Idle bus shows inverted values so stale ones are never trusted
  task automatic wr(input logic [7:0] a, d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    d = reg_rdata;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask
endmodule // mib_host_model

// >>> tb/mib_counter_indirect_read_tb.sv
// Self-checking bench of the counter store, host model in front.
// Assumes default parameters: five ports, 32 counters each.
`timescale 1ns/1ps
module mib_counter_indirect_read_tb;
  localparam logic [39:0] vld = 40'h20_0000_0000;
  logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr, reg_rd, fetch_busy;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [159:0] port_evt = '0;
  logic [4:0] rx_done = '0, tx_done = '0, tx_ok = '0;
  logic [4:0] rx_drop = '0, tx_drop = '0;
  logic [4:0][10:0] rx_len = '0, tx_len = '0;
  int n_fail = 0, num_checks = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  mib_host_model i_host (.ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  mib_counter_indirect_read i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_busy(fetch_busy),
    .port_evt(port_evt), .rx_done(rx_done), .rx_len(rx_len),
    .tx_done(tx_done), .tx_ok(tx_ok), .tx_len(tx_len),
    .rx_drop(rx_drop), .tx_drop(tx_drop));
  task automatic results();
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Repeats the fetch once if the entry comes back without its valid bit
  task automatic get(input logic [7:0] sel, idx, output logic [39:0] e);
    for (int t = 0; t < 2; t++) begin
      if (t == 0 || !e[37]) begin
        i_host.wr(8'h6e, sel);
        i_host.wr(8'h6f, idx);
        repeat (2) @(negedge ref_clk);
        for (int i = 0; i < 5; i++)
          i_host.rd(8'(8'h74 + i), e[39-8*i -: 8]);
      end
    end
  endtask
  task automatic s_port();
    logic [39:0] e;
    for (int p = 0; p < 5; p++) begin
      repeat (p + 1) begin
        @(negedge ref_clk) port_evt[p*32+13] = 1'b1;
        @(negedge ref_clk) port_evt[p*32+13] = 1'b0;
      end
      get(8'h1c, 8'(p*32 + 13), e);
      chk(e, vld | 40'(p + 1));
      get(8'h1c, 8'(p*32 + 13), e);
      chk(e, vld);
    end
  endtask
  task automatic s_agg();
    logic [39:0] e;
    @(negedge ref_clk);
    for (int p = 0; p < 5; p++) begin
      rx_len[p] = 11'(100 + p);
      tx_len[p] = 11'(64*(p + 1));
    end
    {rx_done, tx_done, tx_ok, rx_drop, tx_drop} = '1;
    // Second cycle: failed transmit must not add bytes
    @(negedge ref_clk) {tx_ok, rx_drop} = '0;
    @(negedge ref_clk) {rx_done, tx_done, tx_drop} = '0;
    for (int p = 0; p < 5; p++) begin
      get(8'h1d, 8'(4*p), e);
      chk(e, vld | 40'(2*(100 + p)));
      get(8'h1d, 8'(4*p + 1), e);
      chk(e, vld | 40'(64*(p + 1)));
      get(8'h1d, 8'(4*p + 2), e);
      chk(e, vld | 40'd1);
      get(8'h1d, 8'(4*p + 3), e);
      chk(e, vld | 40'd2);
    end
    get(8'h1d, 8'h11, e);
    chk(e, vld);
  endtask
  task automatic s_ovf();
    logic [39:0] e;
    @(negedge ref_clk) rx_drop[0] = 1'b1;
    repeat (65537) @(negedge ref_clk);
    rx_drop[0] = 1'b0;
    get(8'h1d, 8'h02, e);
    chk(e, 40'h60_0000_0001);
    get(8'h1d, 8'h02, e);
    chk(e, vld);
  endtask
  task automatic s_misc();
    logic [7:0] b;
    i_host.rd(8'h70, b);
    chk(40'(b), 40'h0);
    i_host.rd(8'h6e, b);
    chk(40'(b), 40'h1d);
  endtask
  // Longest test holds a drop line for 65537 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    s_port();
    s_agg();
    s_ovf();
    s_misc();
    results();
  end
endmodule // mib_counter_indirect_read_tb
